// [common/fsp_pkg.sv]
// Shared constants for the streaming port layer of the filter core.
// Assumes a single user of these constants per elaboration; all widths are fixed.
package fsp_pkg;

	localparam int WIRES         = 4;
	localparam int SAMPLE_W      = 8;
	localparam int BANK_W        = 2;
	localparam int FIELD_W       = SAMPLE_W + BANK_W;
	localparam int SINK_W        = FIELD_W * WIRES;
	localparam int OUT_W         = 8;
	localparam int SRC_W         = OUT_W * WIRES;
	localparam int CHAN_PER_WIRE = 2;
	localparam int CHAN_W        = 1;
	localparam int COEF_W        = 8;
	localparam int COEF_DEPTH    = 1 << BANK_W;

	localparam logic [CHAN_W-1:0] CHAN_FIRST = 1'h0;
	localparam logic [CHAN_W-1:0] CHAN_LAST  = 1'h1;

	localparam logic [1:0] ERR_NONE      = 2'h0;
	localparam logic [1:0] ERR_MISS_SOP  = 2'h1;
	localparam logic [1:0] ERR_MISS_EOP  = 2'h2;
	localparam logic [1:0] ERR_UNEXP_EOP = 2'h3;

	localparam int          WB_ADR_W    = 8;
	localparam logic [5:0]  IDX_CTRL    = 6'h00;
	localparam logic [5:0]  IDX_STATUS  = 6'h01;
	localparam logic [5:0]  IDX_MASK    = 6'h02;
	localparam logic [5:0]  IDX_COUNT   = 6'h03;

	localparam int          STAT_W          = 4;
	localparam int          ST_ERR_IN       = 0;
	localparam int          ST_MISS_SOP     = 1;
	localparam int          ST_MISS_EOP     = 2;
	localparam int          ST_UNEXP_EOP    = 3;
	localparam int          CTRL_BP_BIT     = 0;

	localparam logic        CTRL_BP_RESET   = 1'h1;
	localparam logic [3:0]  STATUS_RESET    = 4'h0;
	localparam logic [3:0]  MASK_RESET      = 4'h0;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [7:0]  COEF_RESET      = 8'h01;

endpackage

// [logic/fsp_coef_mem.sv]
// Coefficient store, one word per coefficient bank.
// Written on the coefficient clock, read on the main clock with a registered output.
`timescale 1ns/1ps
module fsp_coef_mem (
	input  wire logic                            wr_clock,
	input  wire logic                            wr_en,
	input  wire logic [fsp_pkg::BANK_W-1:0]      wr_addr,
	input  wire logic [fsp_pkg::COEF_W-1:0]      wr_data,
	input  wire logic                            rd_clock,
	input  wire logic                            rd_en,
	input  wire logic [fsp_pkg::BANK_W-1:0]      rd_addr,
	output logic      [fsp_pkg::COEF_W-1:0]      rd_data
);
	import fsp_pkg::*;

	// Banks power up undefined, so every bank must be reloaded before a sample selects it.
	// A bank reloaded while samples select it may be read mid-write; reload between streams.
	logic [COEF_W-1:0] mem_reg [0:COEF_DEPTH-1];

	always_ff @(posedge wr_clock) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge rd_clock) begin
		if (rd_en) begin
			rd_data <= mem_reg[rd_addr];
		end
	end

endmodule

// [logic/fsp_stream_top.sv]
// Streaming port layer of the filter core: sink, a one-tap scaling stage, source,
// a classic Wishbone register slave and a coefficient reload port on its own clock.
// Assumes upstream and downstream logic run on the main clock; the main reset pin
// may be let go at any time, as it is brought into step with the clock here.
`timescale 1ns/1ps
module fsp_stream_top (
	input  wire logic                            clock,
	input  wire logic                            main_rst_n,
	input  wire logic                            coef_clock,
	input  wire logic                            coef_areset,
	input  wire logic [fsp_pkg::BANK_W-1:0]      coef_in_address,
	input  wire logic                            coef_in_we,
	input  wire logic [fsp_pkg::COEF_W-1:0]      coef_in_data,
	input  wire logic                            sink_valid,
	output logic                                 sink_ready,
	input  wire logic [fsp_pkg::SINK_W-1:0]      sink_data,
	input  wire logic                            sink_sop,
	input  wire logic                            sink_eop,
	input  wire logic [1:0]                      sink_error,
	output logic                                 source_valid,
	input  wire logic                            source_ready,
	output logic      [fsp_pkg::SRC_W-1:0]       source_data,
	output logic                                 source_sop,
	output logic                                 source_eop,
	output logic      [fsp_pkg::CHAN_W-1:0]      source_channel,
	output logic      [1:0]                      source_error,
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [fsp_pkg::WB_ADR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]                      wb_sel_i,
	input  wire logic [31:0]                     wb_dat_i,
	output logic      [31:0]                     wb_dat_o,
	output logic                                 wb_ack_o,
	output logic                                 irq
);
	import fsp_pkg::*;

	function automatic logic [SAMPLE_W-1:0] field_sample(input logic [SINK_W-1:0] d,
	                                                     input int w);
		field_sample = d[w*FIELD_W +: SAMPLE_W];
	endfunction

	function automatic logic [BANK_W-1:0] field_bank(input logic [SINK_W-1:0] d,
	                                                 input int w);
		field_bank = d[w*FIELD_W + SAMPLE_W +: BANK_W];
	endfunction

	// Register state.
	logic                  bp_enable_reg;
	logic [STAT_W-1:0]     status_reg;
	logic [STAT_W-1:0]     status_next;
	logic [STAT_W-1:0]     mask_reg;
	logic [15:0]           count_reg;
	logic                  ack_reg;
	logic [31:0]           rdata_reg;

	// Pipeline state.
	logic                  s1_valid_reg;
	logic [SINK_W-1:0]     s1_data_reg;
	logic [CHAN_W-1:0]     s1_chan_reg;
	logic [1:0]            s1_err_reg;
	logic [CHAN_W-1:0]     chan_reg;
	logic                  out_valid_reg;
	logic [SRC_W-1:0]      out_data_reg;
	logic [CHAN_W-1:0]     out_chan_reg;
	logic [1:0]            out_err_reg;

	// Coefficient-domain write stage.
	logic                  cw_we_reg;
	logic [BANK_W-1:0]     cw_addr_reg;
	logic [COEF_W-1:0]     cw_data_reg;

	wire                   src_ready_eff = source_ready | ~bp_enable_reg;
	wire                   out_room      = ~out_valid_reg | src_ready_eff;
	wire                   accept        = sink_valid & out_room;
	wire                   out_take      = out_valid_reg & src_ready_eff;

	// Channel tracking: start of packet forces channel 0.
	wire [CHAN_W-1:0]      chan_now      = sink_sop ? CHAN_FIRST : chan_reg;
	wire                   now_last      = (chan_now == CHAN_LAST);
	wire [CHAN_W-1:0]      chan_next     = (sink_eop || now_last) ? CHAN_FIRST :
	                                       CHAN_W'(chan_now + 1'b1);
	wire                   ev_err_in     = accept & (sink_error != ERR_NONE);
	wire                   ev_miss_sop   = accept & ~sink_sop & (chan_reg == CHAN_FIRST);
	wire                   ev_miss_eop   = accept & ((sink_sop & (chan_reg != CHAN_FIRST)) |
	                                                 (~sink_eop & now_last));
	wire                   ev_unexp_eop  = accept & sink_eop & ~now_last;
	wire [1:0]             err_code      = (sink_error != ERR_NONE) ? sink_error :
	                                       ev_unexp_eop ? ERR_UNEXP_EOP :
	                                       ev_miss_eop  ? ERR_MISS_EOP  :
	                                       ev_miss_sop  ? ERR_MISS_SOP  : ERR_NONE;

	// Ready depends only on output room, never on sink valid.
	assign sink_ready = out_room;

	// The pin drops every main-clock register except the coefficient read data at once, and is let go only in step with the clock,
	// so no register leaves reset a cycle before its neighbours.
	logic                  rst_meta_reg;
	logic                  rst_sync_n_reg;

	always_ff @(posedge clock or negedge main_rst_n) begin
		if (!main_rst_n) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	// Halting: nothing moves forward unless a sample is accepted.
	always_ff @(posedge clock or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			s1_valid_reg <= 1'b0;
			s1_data_reg  <= '0;
			s1_chan_reg  <= CHAN_FIRST;
			s1_err_reg   <= ERR_NONE;
			chan_reg     <= CHAN_FIRST;
		end else if (accept) begin
			s1_valid_reg <= 1'b1;
			s1_data_reg  <= sink_data;
			s1_chan_reg  <= chan_now;
			s1_err_reg   <= err_code;
			chan_reg     <= chan_next;
		end
	end

	// Coefficient reads share the accept enable so they line up with stage one.
	logic [COEF_W-1:0]     coef_rd [WIRES];
	logic [SRC_W-1:0]      out_data_next;

	genvar w;
	generate
		for (w = 0; w < WIRES; w++) begin : g_wire
			logic [SAMPLE_W+COEF_W-1:0] product;
			fsp_coef_mem u_mem (
				.wr_clock (coef_clock),
				.wr_en    (cw_we_reg),
				.wr_addr  (cw_addr_reg),
				.wr_data  (cw_data_reg),
				.rd_clock (clock),
				.rd_en    (accept),
				.rd_addr  (field_bank(sink_data, w)),
				.rd_data  (coef_rd[w])
			);
			assign product = field_sample(s1_data_reg, w) * coef_rd[w];
			assign out_data_next[w*OUT_W +: OUT_W] = product[OUT_W-1:0];
		end
	endgenerate

	// Output holds until taken; it is cleared only when drained with no new sample.
	always_ff @(posedge clock or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
			out_chan_reg  <= CHAN_FIRST;
			out_err_reg   <= ERR_NONE;
		end else if (accept) begin
			out_valid_reg <= s1_valid_reg;
			out_data_reg  <= out_data_next;
			out_chan_reg  <= s1_chan_reg;
			out_err_reg   <= s1_err_reg;
		end else if (out_take) begin
			out_valid_reg <= 1'b0;
		end
	end

	assign source_valid   = out_valid_reg;
	assign source_data    = out_data_reg;
	assign source_channel = out_chan_reg;
	assign source_sop     = out_valid_reg & (out_chan_reg == CHAN_FIRST);
	assign source_eop     = out_valid_reg & (out_chan_reg == CHAN_LAST);
	assign source_error   = out_err_reg;

	// Coefficient reload domain, reset by its own asynchronous reset.
	always_ff @(posedge coef_clock or posedge coef_areset) begin
		if (coef_areset) begin
			cw_we_reg   <= 1'b0;
			cw_addr_reg <= '0;
			cw_data_reg <= '0;
		end else begin
			cw_we_reg   <= coef_in_we;
			cw_addr_reg <= coef_in_address;
			cw_data_reg <= coef_in_data;
		end
	end

	// Wishbone slave: one wait state, ack for exactly one cycle.
	wire [5:0]             wb_idx     = wb_adr_i[7:2];
	wire                   wb_req     = wb_cyc_i & wb_stb_i & ~ack_reg;
	// Writes land at the edge where the master sees ack, so a cycle that the
	// master abandons before its ack leaves every register untouched.
	wire                   wb_wr_lo   = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
	wire                   wr_ctrl    = wb_wr_lo & (wb_idx == IDX_CTRL);
	wire                   wr_status  = wb_wr_lo & (wb_idx == IDX_STATUS);
	wire                   wr_mask    = wb_wr_lo & (wb_idx == IDX_MASK);
	wire [STAT_W-1:0]      ev_vec     = {ev_unexp_eop, ev_miss_eop, ev_miss_sop, ev_err_in};
	wire [STAT_W-1:0]      clr_vec    = wr_status ? wb_dat_i[STAT_W-1:0] : '0;
	wire [31:0]            rd_mux     =
		(wb_idx == IDX_CTRL)   ? {31'h0, bp_enable_reg} :
		(wb_idx == IDX_STATUS) ? {28'h0, status_reg} :
		(wb_idx == IDX_MASK)   ? {28'h0, mask_reg} :
		(wb_idx == IDX_COUNT)  ? {16'h0, count_reg} : 32'h0;

	// A new event wins over a write-one-to-clear in the same cycle.
	assign status_next = (status_reg & ~clr_vec) | ev_vec;

	always_ff @(posedge clock or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			ack_reg       <= 1'b0;
			rdata_reg     <= 32'h0;
			bp_enable_reg <= CTRL_BP_RESET;
			status_reg    <= STATUS_RESET;
			mask_reg      <= MASK_RESET;
			count_reg     <= COUNT_RESET;
		end else begin
			ack_reg    <= wb_req;
			rdata_reg  <= wb_req ? rd_mux : 32'h0;
			status_reg <= status_next;
			if (wr_ctrl) begin
				bp_enable_reg <= wb_dat_i[CTRL_BP_BIT];
			end
			if (wr_mask) begin
				mask_reg <= wb_dat_i[STAT_W-1:0];
			end
			if (accept) begin
				count_reg <= 16'(count_reg + 1'b1);
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign irq      = |(status_reg & mask_reg);

endmodule

// [tb/fsp_stream_assertions.sv]
// Port checks of the streaming layer, main clock domain only.
// Assumes a bind to the top module; the reload port is not watched.
`timescale 1ns/1ps
module fsp_stream_assertions (
	input wire logic                        clock,
	input wire logic                        main_rst_n,
	input wire logic                        sink_valid,
	input wire logic                        sink_ready,
	input wire logic                        source_valid,
	input wire logic                        source_ready,
	input wire logic [fsp_pkg::SRC_W-1:0]   source_data,
	input wire logic                        source_sop,
	input wire logic                        source_eop,
	input wire logic [fsp_pkg::CHAN_W-1:0]  source_channel,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_ack_o
);
	import fsp_pkg::*;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!main_rst_n);
	sequence wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence taken_idle;
		source_valid && source_ready && !sink_valid;
	endsequence
	chk_ack_next: assert property (wb_req |=> wb_ack_o) else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	chk_ready_idle: assert property (!source_valid |-> sink_ready) else $error("ready low");
	chk_halt_idle: assert property (!sink_valid && !source_valid |=> !source_valid)
		else $error("output without input");
	chk_take_drop: assert property (taken_idle |=> !source_valid) else $error("valid kept");
	chk_stall_hold: assert property (source_valid && !sink_ready |=>
		source_valid && $stable(source_data)) else $error("stalled output lost");
	chk_sop_chan: assert property (source_sop |-> source_valid &&
		source_channel == CHAN_FIRST) else $error("sop channel");
	chk_eop_chan: assert property (source_eop |-> source_valid &&
		source_channel == CHAN_LAST) else $error("eop channel");
endmodule

// [tb/fsp_down_model.sv]
// Downstream consumer model: raises source ready unless told to stall.
// Assumes the bench changes stall away from the clock edge or by NBA.
`timescale 1ns/1ps
module fsp_down_model (
	input  wire logic clock,
	input  wire logic stall,
	output logic      source_ready
);
	// Registered, so a stall request lands one edge late as in real logic.
	always @(posedge clock) begin
		source_ready <= !stall;
	end
endmodule

// [tb/fsp_stream_top_tb.sv]
// Bench for the streaming layer: registers, reload, stream, interrupt, backpressure.
// Assumes fsp_pkg, the design, the checker and the downstream model compile first.
`timescale 1ns/1ps
module fsp_stream_top_tb;
	import fsp_pkg::*;
	logic clock = 1'h0, coef_clock = 1'h0, main_rst_n = 1'h0, coef_areset = 1'h1;
	logic coef_in_we = 1'h0, sink_valid = 1'h0, sink_sop = 1'h0, sink_eop = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, stall = 1'h0, bp = 1'h1;
	logic [BANK_W-1:0] coef_in_address = 2'h0;
	logic [COEF_W-1:0] coef_in_data = 8'h00;
	logic [SINK_W-1:0] sink_data = '0;
	logic [1:0] sink_error = 2'h0, source_error;
	logic [WB_ADR_W-1:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [SRC_W-1:0] source_data;
	logic [CHAN_W-1:0] source_channel;
	logic sink_ready, source_valid, source_ready, source_sop, source_eop, wb_ack_o, irq;
	logic [35:0] q[$];
	int n_fail = 0, num_checks = 0;
	fsp_stream_top u_dut (.clock, .main_rst_n, .coef_clock, .coef_areset, .coef_in_address,
		.coef_in_we, .coef_in_data, .sink_valid, .sink_ready, .sink_data, .sink_sop, .sink_eop,
		.sink_error, .source_valid, .source_ready, .source_data, .source_sop, .source_eop,
		.source_channel, .source_error, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq);
	fsp_down_model u_down (.clock, .stall, .source_ready);
	always #12.5 clock = ~clock;
	always #30 coef_clock = ~coef_clock; // Slower and unrelated in phase.
	task automatic chk(input string n, input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge clock);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'h1);
		if (!w) chk("register", wb_dat_o, e);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic snd_raw(input logic [7:0] s, input logic sop, input logic eop,
		input logic [1:0] e, input logic ch, input logic [1:0] ee);
		logic [SINK_W-1:0] d;
		logic [SRC_W-1:0] x;
		for (int w = 0; w < WIRES; w++) begin
			d[FIELD_W*w +: FIELD_W] = {2'(w), 8'(s + 8'h11 * w)};
			x[OUT_W*w +: OUT_W] = 8'((s + 8'h11 * w) * (w + 1));
		end
		sink_data <= d;
		sink_sop <= sop;
		sink_eop <= eop;
		sink_error <= e;
		sink_valid <= 1'h1;
		do @(posedge clock); while (sink_ready !== 1'h1);
		q.push_back({!ch, ch, ee, x});
	endtask
	task automatic snd(input logic [7:0] s, input logic ch, input logic [1:0] e);
		snd_raw(s, !ch, ch, e, ch, e);
	endtask
	// Results are compared in order as the downstream side takes them.
	always @(posedge clock) begin
		if (main_rst_n && source_valid === 1'h1 && (source_ready || !bp))
			chk("result", {source_sop, source_eop, source_error, source_data}, q.pop_front());
	end
	task automatic t_regs();
		logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40};
		for (int i = 0; i < 5; i++) wb(1'h0, a[i], 32'h0, i == 0 ? 32'h1 : 32'h0);
		wb(1'h1, 8'h0C, 32'hFFFF, 32'h0);
		wb(1'h0, 8'h0C, 32'h0, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_stream();
		for (int b = 0; b < COEF_DEPTH; b++) begin
			@(posedge coef_clock);
			coef_in_we <= 1'h1;
			coef_in_address <= 2'(b);
			coef_in_data <= 8'(b + 1);
		end
		@(posedge coef_clock);
		coef_in_we <= 1'h0;
		repeat (4) @(posedge coef_clock);
		@(posedge clock);
		for (int k = 0; k < 8; k++) begin
			if (k == 3) begin
				sink_valid <= 1'h0;
				repeat (3) @(posedge clock);
			end
			snd(8'(8'h05 + 8'h0D * k), k[0], k < 4 ? 2'(k) : 2'h0);
		end
		sink_valid <= 1'h0;
		wb(1'h0, 8'h0C, 32'h0, 32'h8);
		$display("t_stream done");
	endtask
	task automatic t_irq();
		wb(1'h0, 8'h04, 32'h0, 32'h1);
		chk("irq masked", irq, 1'h0);
		wb(1'h1, 8'h08, 32'h1, 32'h0);
		// The mask lands on the ack edge, so the level is looked at just after it.
		#1;
		chk("irq on", irq, 1'h1);
		wb(1'h1, 8'h04, 32'hF, 32'h0);
		wb(1'h0, 8'h04, 32'h0, 32'h0);
		chk("irq off", irq, 1'h0);
		$display("t_irq done");
	endtask
	task automatic t_bp();
		stall <= 1'h1;
		repeat (2) @(posedge clock);
		snd(8'h21, 1'h0, 2'h0);
		sink_valid <= 1'h0;
		repeat (4) @(posedge clock);
		#1;
		chk("sink ready", sink_ready, 1'h0);
		chk("held valid", source_valid, 1'h1);
		stall <= 1'h0;
		wb(1'h1, 8'h00, 32'h0, 32'h0);
		bp = 1'h0;
		stall <= 1'h1;
		repeat (2) @(posedge clock);
		snd(8'h31, 1'h1, 2'h0);
		#1;
		chk("free ready", sink_ready, 1'h1);
		sink_valid <= 1'h0;
		$display("t_bp done");
	endtask
	task automatic t_rst();
		wb(1'h1, 8'h00, 32'h1, 32'h0);
		bp = 1'h1;
		snd(8'h51, 1'h0, 2'h0);
		sink_valid <= 1'h0;
		@(posedge clock);
		main_rst_n <= 1'h0;
		#1;
		chk("async reset", source_valid, 1'h0);
		q.delete();
		stall <= 1'h0;
		repeat (3) @(posedge clock);
		main_rst_n <= 1'h1;
		repeat (2) @(posedge clock);
		wb(1'h0, 8'h00, 32'h0, 32'h1);
		wb(1'h0, 8'h0C, 32'h0, 32'h0);
		snd_raw(8'h41, 1'h0, 1'h0, 2'h0, 1'h0, ERR_MISS_SOP);
		snd_raw(8'h42, 1'h0, 1'h0, 2'h0, 1'h1, ERR_MISS_EOP);
		snd_raw(8'h43, 1'h0, 1'h1, 2'h0, 1'h0, ERR_UNEXP_EOP);
		snd(8'h44, 1'h0, 2'h0);
		sink_valid <= 1'h0;
		wb(1'h0, 8'h04, 32'h0, 32'hE);
		chk("pending", q.size(), 36'h1);
		$display("t_rst done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		main_rst_n <= 1'h1;
		@(posedge coef_clock);
		coef_areset <= 1'h0;
		// The design lets go of reset two edges after the pin does.
		repeat (2) @(posedge clock);
		t_regs();
		t_stream();
		t_irq();
		t_bp();
		t_rst();
		print_verdict();
	end
	// The whole sequence needs under two hundred cycles; a hang ends far later.
	initial begin
		repeat (4000) @(posedge clock);
		n_fail++;
		print_verdict();
	end
endmodule
bind fsp_stream_top fsp_stream_assertions u_chk (.clock, .main_rst_n, .sink_valid, .sink_ready,
	.source_valid, .source_ready, .source_data, .source_sop, .source_eop, .source_channel,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o);
